//--- inc/prs_pkg.sv
// Constants and types shared by the register synchronizer and its delay engine
package prs_pkg;

   // ---------------------------------------------------------------
   // Bus geometry
   // ---------------------------------------------------------------
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned BE_W = 4;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h04;
   localparam logic [ADDR_W-1:0] OFF_READ_REQUEST_REGISTER = 6'h08;
   localparam logic [ADDR_W-1:0] OFF_SCRATCH = 6'h0c;
   localparam logic [ADDR_W-1:0] OFF_CORECFG = 6'h10;
   localparam logic [ADDR_W-1:0] OFF_COUNT = 6'h14;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int unsigned CTRL_SOFT_RESET_BIT_BIT = 0;
   localparam int unsigned CTRL_ENABLE_BIT = 1;
   localparam int unsigned STATUS_BUSY_BIT = 0;
   localparam int unsigned RRQ_ADDR_W = 8;
   localparam int unsigned RRQ_CONT_BIT = 14;
   localparam int unsigned RRQ_TRIG_BIT = 15;
   localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Synchronization delay
   // ---------------------------------------------------------------
   localparam int unsigned BUS_PERIOD_NS = 100;
   localparam int unsigned CORE_PERIOD_NS = 100;
   localparam int unsigned SYNC_CORE_PERIODS = 5;
   localparam int unsigned SYNC_BUS_PERIODS = 2;
   localparam int unsigned SYNC_MIN_NS =
      SYNC_CORE_PERIODS * CORE_PERIOD_NS + SYNC_BUS_PERIODS * BUS_PERIOD_NS;
   // Strictly above the lower bound, hence one cycle past the quotient
   localparam int unsigned SYNC_CYCLES = SYNC_MIN_NS / BUS_PERIOD_NS + 1;
   localparam int unsigned SYNC_CNT_W = 5;

   // ---------------------------------------------------------------
   // Operation kinds and bus states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {OP_WRITE, OP_ENABLE, OP_SOFT_RESET_BIT, OP_RREAD, OP_READ_REQUEST_TRIGGER} sync_op_t;
   typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_ACK} bus_state_t;

endpackage : prs_pkg

//--- inc/sync_if.sv
// Handshake between the register front end and the shared delay engine
`timescale 1ns/1ps
interface sync_if;
   logic start;
   logic abort;
   logic run;
   logic busy;
   logic done;

   modport ctrl (output start, output abort, output run, input busy, input done);
   modport eng (input start, input abort, input run, output busy, output done);
endinterface : sync_if

//--- logic/sync_engine.sv
// Shared crossing delay engine: one transfer at a time, paused while the core clock is off
`timescale 1ns/1ps
module sync_engine
   import prs_pkg::*;
#(
   parameter int unsigned SYNC_LEN = SYNC_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Front end handshake
   sync_if.eng sif
);

   logic [SYNC_CNT_W-1:0] cnt_q;
   logic [SYNC_CNT_W-1:0] cnt_d;
   logic busy_q;
   logic busy_d;
   logic done_q;
   logic done_d;

   // Count the crossing down; abort drops it at once
   always_comb begin
      cnt_d = cnt_q;
      busy_d = busy_q;
      done_d = 1'b0;
      if (sif.abort) begin
         busy_d = 1'b0;
         cnt_d = '0;
      end else if (sif.start) begin
         busy_d = 1'b1;
         // done pulse is the last of the SYNC_LEN crossing cycles
         cnt_d = SYNC_CNT_W'(SYNC_LEN - 1);
      end else if (busy_q && sif.run) begin
         if (cnt_q <= SYNC_CNT_W'(1)) begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end
         cnt_d = cnt_q - SYNC_CNT_W'(1);
      end
   end

   // State registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end

   assign sif.busy = busy_q;
   assign sif.done = done_q;

endmodule : sync_engine

//--- logic/peripheral_register_synchronizer.sv
// Peripheral register front end with one shared bus-to-core synchronizer
`timescale 1ns/1ps
module peripheral_register_synchronizer
   import prs_pkg::*;
#(
   parameter int unsigned SYNC_LEN = SYNC_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   input wire logic [BE_W-1:0] avs_byteenable,
   output logic [DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   // Core side
   input wire logic coreClkRun,
   output logic coreEnable,
   output logic syncInProgress
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   bus_state_t busState_q;
   bus_state_t busState_d;
   sync_op_t opKind_q;
   sync_op_t opKind_d;
   logic waitReq_q;
   logic waitReq_d;
   logic [DATA_W-1:0] readData_q;
   logic [DATA_W-1:0] readData_d;
   logic ctrlEnable_q;
   logic ctrlEnable_d;
   logic ctrlSwrst_q;
   logic ctrlSwrst_d;
   logic status_q;
   logic status_d;
   logic [RRQ_ADDR_W-1:0] rreqAddr_q;
   logic [RRQ_ADDR_W-1:0] rreqAddr_d;
   logic rreqCont_q;
   logic rreqCont_d;
   logic rreqValid_q;
   logic rreqValid_d;
   logic repeat_q;
   logic repeat_d;
   logic [DATA_W-1:0] snap_q;
   logic [DATA_W-1:0] snap_d;
   logic [DATA_W-1:0] scratch_q;
   logic [DATA_W-1:0] scratch_d;
   logic [DATA_W-1:0] coreCfg_q;
   logic [DATA_W-1:0] coreCfg_d;
   logic [DATA_W-1:0] coreCount_q;
   logic [DATA_W-1:0] coreCount_d;
   logic coreEnable_q;
   logic coreEnable_d;
   logic [ADDR_W-1:0] opAddr_q;
   logic [ADDR_W-1:0] opAddr_d;
   logic [DATA_W-1:0] pend_q;
   logic [DATA_W-1:0] pend_d;

   // ---------------------------------------------------------------
   // Shared synchronizer
   // ---------------------------------------------------------------
   sync_if sif ();

   sync_engine #(
      .SYNC_LEN(SYNC_LEN)
   ) u_engine (
      .clk(sys_clk),
      .rst_b(rst_b),
      .sif(sif)
   );

   // ---------------------------------------------------------------
   // Access decode
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] beMask;
   logic [DATA_W-1:0] curWord;
   logic [DATA_W-1:0] mrgWord;
   logic engineFree;
   logic hardBusy;
   logic holdAll;
   logic rreqRun;
   logic rreqHit;
   logic [DATA_W-1:0] rreqSrc;

   // Byte lanes, current readback and merged write word
   always_comb begin
      beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
      curWord = RST_WORD;
      unique case (avs_address)
         OFF_CTRL: begin
            curWord[CTRL_ENABLE_BIT] = ctrlEnable_q;
            curWord[CTRL_SOFT_RESET_BIT_BIT] = ctrlSwrst_q;
         end
         OFF_STATUS: curWord[STATUS_BUSY_BIT] = status_q;
         OFF_READ_REQUEST_REGISTER: begin
            curWord[RRQ_ADDR_W-1:0] = rreqAddr_q;
            curWord[RRQ_CONT_BIT] = rreqCont_q;
         end
         OFF_SCRATCH: curWord = scratch_q;
         OFF_CORECFG: curWord = coreCfg_q;
         OFF_COUNT: curWord = snap_q;
         default: curWord = RST_WORD;
      endcase
      mrgWord = (curWord & ~beMask) | (avs_writedata & beMask);
   end

   // Engine occupancy classes; done cycle counts as taken to avoid a race
   // with a continuous restart
   assign engineFree = !sif.busy && !sif.done;
   assign rreqRun = sif.busy && (opKind_q == OP_READ_REQUEST_TRIGGER);
   assign hardBusy = (sif.busy || sif.done) && (opKind_q != OP_READ_REQUEST_TRIGGER);
   assign holdAll = (sif.busy || sif.done) && (opKind_q == OP_ENABLE || opKind_q == OP_SOFT_RESET_BIT);

   // request address compared as byte offset
   assign rreqHit = rreqValid_q && (rreqAddr_q == RRQ_ADDR_W'(OFF_COUNT));

   // Value that a read request captures
   always_comb begin
      if (rreqAddr_q == RRQ_ADDR_W'(OFF_COUNT)) begin
         rreqSrc = coreCount_q;
      end else if (rreqAddr_q == RRQ_ADDR_W'(OFF_CORECFG)) begin
         rreqSrc = coreCfg_q;
      end else begin
         rreqSrc = RST_WORD;
      end
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   // Core updates only land when a crossing completes, so the core value
   // never sees a half-written word even though both sides share a clock
   always_comb begin
      busState_d = busState_q;
      opKind_d = opKind_q;
      waitReq_d = waitReq_q;
      readData_d = readData_q;
      ctrlEnable_d = ctrlEnable_q;
      ctrlSwrst_d = ctrlSwrst_q;
      status_d = status_q;
      rreqAddr_d = rreqAddr_q;
      rreqCont_d = rreqCont_q;
      rreqValid_d = rreqValid_q;
      repeat_d = repeat_q;
      snap_d = snap_q;
      scratch_d = scratch_q;
      coreCfg_d = coreCfg_q;
      coreCount_d = coreCount_q;
      coreEnable_d = coreEnable_q;
      opAddr_d = opAddr_q;
      pend_d = pend_q;
      sif.start = 1'b0;
      sif.abort = 1'b0;
      // engine idles while the core clock is stopped
      sif.run = coreClkRun;

      // Core counter advances only with the core clock running
      if (coreEnable_q && coreClkRun) begin
         coreCount_d = coreCount_q + DATA_W'(1);
      end

      // Completion of the crossing in flight
      if (sif.done) begin
         unique case (opKind_q)
            OP_WRITE: begin
               if (opAddr_q == OFF_CORECFG) begin
                  coreCfg_d = pend_q;
               end else begin
                  coreCount_d = pend_q;
               end
               status_d = 1'b0;
            end
            OP_ENABLE: begin
               coreEnable_d = pend_q[CTRL_ENABLE_BIT];
               status_d = 1'b0;
            end
            OP_SOFT_RESET_BIT: begin
               // reset lands, bit and flag cleared
               coreEnable_d = 1'b0;
               coreCfg_d = RST_WORD;
               coreCount_d = RST_WORD;
               ctrlEnable_d = 1'b0;
               ctrlSwrst_d = 1'b0;
               scratch_d = RST_WORD;
               rreqAddr_d = '0;
               rreqCont_d = 1'b0;
               rreqValid_d = 1'b0;
               snap_d = RST_WORD;
               status_d = 1'b0;
            end
            OP_RREAD: begin
               snap_d = coreCount_q;
            end
            OP_READ_REQUEST_TRIGGER: begin
               snap_d = rreqSrc;
               rreqValid_d = 1'b1;
               status_d = 1'b0;
               if (rreqCont_q) begin
                  sif.start = 1'b1;
                  repeat_d = 1'b1;
               end
            end
         endcase
      end

      unique case (busState_q)
         BUS_IDLE: begin
            if (avs_write) begin
               // enable or reset sync holds every write
               if (holdAll) begin
                  busState_d = BUS_IDLE;
               end else if (avs_address == OFF_CTRL ||
                            avs_address == OFF_CORECFG ||
                            avs_address == OFF_COUNT ||
                            (avs_address == OFF_READ_REQUEST_REGISTER &&
                             (mrgWord[RRQ_TRIG_BIT] || mrgWord[RRQ_CONT_BIT]))) begin
                  if (rreqRun) begin
                     // another sync stops the read request
                     sif.abort = 1'b1;
                     rreqCont_d = 1'b0;
                     rreqValid_d = 1'b0;
                     status_d = 1'b0;
                  end else if (engineFree) begin
                     sif.start = 1'b1;
                     repeat_d = 1'b0;
                     opAddr_d = avs_address;
                     pend_d = mrgWord;
                     rreqValid_d = 1'b0;
                     rreqCont_d = 1'b0;
                     status_d = 1'b1;
                     if (avs_address == OFF_CTRL) begin
                        ctrlEnable_d = mrgWord[CTRL_ENABLE_BIT];
                        if (mrgWord[CTRL_SOFT_RESET_BIT_BIT]) begin
                           // soft reset reads one at once
                           ctrlSwrst_d = 1'b1;
                           opKind_d = OP_SOFT_RESET_BIT;
                        end else begin
                           opKind_d = OP_ENABLE;
                        end
                     end else if (avs_address == OFF_READ_REQUEST_REGISTER) begin
                        opKind_d = OP_READ_REQUEST_TRIGGER;
                        rreqAddr_d = mrgWord[RRQ_ADDR_W-1:0];
                        rreqCont_d = mrgWord[RRQ_CONT_BIT];
                     end else begin
                        opKind_d = OP_WRITE;
                     end
                     waitReq_d = 1'b0;
                     busState_d = BUS_ACK;
                  end
                  // otherwise held; started once engine frees
               end else begin
                  // Bus domain registers take the write directly
                  if (avs_address == OFF_SCRATCH) begin
                     scratch_d = mrgWord;
                  end else if (avs_address == OFF_READ_REQUEST_REGISTER) begin
                     rreqAddr_d = mrgWord[RRQ_ADDR_W-1:0];
                  end
                  waitReq_d = 1'b0;
                  busState_d = BUS_ACK;
               end
            end else if (avs_read) begin
               if (avs_address == OFF_COUNT) begin
                  if (rreqHit && !rreqRun) begin
                     readData_d = snap_q;
                     waitReq_d = 1'b0;
                     busState_d = BUS_ACK;
                  end else if (rreqHit && repeat_q) begin
                     readData_d = snap_q;
                     waitReq_d = 1'b0;
                     busState_d = BUS_ACK;
                  end else if (rreqRun && repeat_q) begin
                     sif.abort = 1'b1;
                     rreqCont_d = 1'b0;
                     rreqValid_d = 1'b0;
                  end else if (engineFree) begin
                     sif.start = 1'b1;
                     opKind_d = OP_RREAD;
                     opAddr_d = avs_address;
                     busState_d = BUS_WAIT;
                  end
                  // first wait for the crossing in flight
               end else if (avs_address == OFF_CORECFG && hardBusy &&
                            opKind_q == OP_WRITE && opAddr_q == OFF_CORECFG) begin
                  busState_d = BUS_IDLE;
               end else begin
                  // static and bus registers answer at once
                  readData_d = curWord;
                  waitReq_d = 1'b0;
                  busState_d = BUS_ACK;
               end
            end
         end
         BUS_WAIT: begin
            // waitrequest stays high through the crossing
            if (sif.done) begin
               readData_d = coreCount_q;
               waitReq_d = 1'b0;
               busState_d = BUS_ACK;
            end
         end
         BUS_ACK: begin
            waitReq_d = 1'b1;
            busState_d = BUS_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // All state from one clocked process, waitrequest high out of reset
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         busState_q <= BUS_IDLE;
         opKind_q <= OP_WRITE;
         waitReq_q <= 1'b1;
         readData_q <= RST_WORD;
         ctrlEnable_q <= 1'b0;
         ctrlSwrst_q <= 1'b0;
         status_q <= 1'b0;
         rreqAddr_q <= '0;
         rreqCont_q <= 1'b0;
         rreqValid_q <= 1'b0;
         repeat_q <= 1'b0;
         snap_q <= RST_WORD;
         scratch_q <= RST_WORD;
         coreCfg_q <= RST_WORD;
         coreCount_q <= RST_WORD;
         coreEnable_q <= 1'b0;
         opAddr_q <= '0;
         pend_q <= RST_WORD;
      end else begin
         busState_q <= busState_d;
         opKind_q <= opKind_d;
         waitReq_q <= waitReq_d;
         readData_q <= readData_d;
         ctrlEnable_q <= ctrlEnable_d;
         ctrlSwrst_q <= ctrlSwrst_d;
         status_q <= status_d;
         rreqAddr_q <= rreqAddr_d;
         rreqCont_q <= rreqCont_d;
         rreqValid_q <= rreqValid_d;
         repeat_q <= repeat_d;
         snap_q <= snap_d;
         scratch_q <= scratch_d;
         coreCfg_q <= coreCfg_d;
         coreCount_q <= coreCount_d;
         coreEnable_q <= coreEnable_d;
         opAddr_q <= opAddr_d;
         pend_q <= pend_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // crossing never bypassed even with equal clocks
   assign avs_waitrequest = waitReq_q;
   assign avs_readdata = readData_q;
   assign coreEnable = coreEnable_q;
   assign syncInProgress = status_q;

endmodule : peripheral_register_synchronizer

//--- test/prs_checker.sv
// Port-level assertions for the register synchronizer
`timescale 1ns/1ps
module prs_checker
   import prs_pkg::*;
#(
   parameter int unsigned SYNC_LEN = SYNC_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Bus
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   input wire logic [BE_W-1:0] avs_byteenable,
   input wire logic [DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Core side
   input wire logic coreClkRun,
   input wire logic coreEnable,
   input wire logic syncInProgress
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   // Answers last one cycle; nothing answers without a request
   a_ack_one_cycle: assert property (
      !avs_waitrequest |=> avs_waitrequest) else $error("answer held");
   a_idle_wait: assert property (
      !avs_read && !avs_write |=> avs_waitrequest) else $error("answer without request");
   a_bus_rd_fast: assert property (
      $rose(avs_read) && (avs_address == OFF_SCRATCH || avs_address == OFF_STATUS)
      |-> ##[1:2] !avs_waitrequest) else $error("bus read stalled");
   a_cfg_busy: assert property (
      avs_write && !avs_waitrequest && avs_address == OFF_CORECFG |-> syncInProgress)
      else $error("flag not set by core write");
   a_en_busy: assert property (
      avs_write && !avs_waitrequest && avs_address == OFF_CTRL && avs_byteenable[0]
      && avs_writedata[CTRL_ENABLE_BIT] && !coreEnable |-> syncInProgress)
      else $error("flag not set by enable");
   // Enable reaches the core only through a crossing
   a_en_crossed: assert property (
      $changed(coreEnable) |-> $past(syncInProgress) || $past(syncInProgress, 2))
      else $error("enable bypassed sync");
   a_busy_hold: assert property (
      $rose(syncInProgress) |=> syncInProgress [*6]) else $error("sync too short");
   a_busy_ends: assert property (
      $rose(syncInProgress) && coreClkRun |-> ##[1:40] !syncInProgress)
      else $error("sync never ends");
endmodule : prs_checker

bind peripheral_register_synchronizer prs_checker #(.SYNC_LEN(SYNC_LEN)) chk (
   .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .coreClkRun(coreClkRun), .coreEnable(coreEnable), .syncInProgress(syncInProgress));

//--- test/avalon_master_model.sv
// Bus master model standing in for the processor
`timescale 1ns/1ps
module avalon_master_model
   import prs_pkg::*;
(
   // Clock
   input wire logic sys_clk,
   // Request
   output logic [ADDR_W-1:0] address,
   output logic read,
   output logic write,
   output logic [DATA_W-1:0] writedata,
   output logic [BE_W-1:0] byteenable,
   // Answer
   input wire logic waitrequest
);
   // Idle bus at time zero
   initial begin
      {address, read, write, writedata, byteenable} = '0;
   end

   // One transfer; released data shows the inverse so stale values never pass
   task automatic xfer(input logic isWr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, output int lat);
      lat = 0;
      @(posedge sys_clk);
      address <= a;
      writedata <= d;
      byteenable <= 4'hf;
      read <= !isWr;
      write <= isWr;
      // wait out stall, sampled on the rising edge that completes it
      do begin
         @(posedge sys_clk);
         lat++;
      end while (waitrequest !== 1'b0 && lat < 300);
      read <= 1'b0;
      write <= 1'b0;
      writedata <= ~d;
   endtask : xfer
endmodule : avalon_master_model

//--- test/peripheral_register_synchronizer_tb.sv
// Self-checking bench for the register synchronizer
`timescale 1ns/1ps
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin badCount++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module peripheral_register_synchronizer_tb;
   import prs_pkg::*;
   logic sys_clk, rst_b, coreClkRun, avs_read, avs_write, avs_waitrequest;
   logic coreEnable, syncInProgress;
   logic [ADDR_W-1:0] avs_address;
   logic [DATA_W-1:0] avs_writedata, avs_readdata, r, lastRd;
   logic [BE_W-1:0] avs_byteenable;
   logic [DATA_W-1:0] expQ[$], mskQ[$];
   logic [ADDR_W-1:0] offs[6] = '{OFF_CTRL, OFF_STATUS, OFF_SCRATCH, OFF_CORECFG, 6'h3c, OFF_COUNT};
   int badCount = 0, nCompared = 0, lat, i;

   peripheral_register_synchronizer dut (.sys_clk(sys_clk), .rst_b(rst_b),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .coreClkRun(coreClkRun), .coreEnable(coreEnable), .syncInProgress(syncInProgress));
   avalon_master_model bfm (.sys_clk(sys_clk), .address(avs_address), .read(avs_read),
      .write(avs_write), .writedata(avs_writedata), .byteenable(avs_byteenable),
      .waitrequest(avs_waitrequest));

   // Clock
   always #50 sys_clk = ~sys_clk;

   // Read answers checked against the oldest note, at the edge that completes the read
   always @(posedge sys_clk) begin
      if (avs_read && avs_waitrequest === 1'b0) begin
         lastRd = avs_readdata;
         `CHK(avs_readdata & mskQ[0], expQ[0] & mskQ[0])
         void'(expQ.pop_front());
         void'(mskQ.pop_front());
      end
   end

   task tally_and_finish();
      if (badCount == 0 && nCompared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   task automatic hang(input logic bad);
      if (bad) begin
         badCount++;
         tally_and_finish();
      end
   endtask : hang

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      bfm.xfer(1'b1, a, d, lat);
      hang(lat >= 300);
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
                     input logic [DATA_W-1:0] m);
      expQ.push_back(e);
      mskQ.push_back(m);
      bfm.xfer(1'b0, a, '0, lat);
      hang(lat >= 300);
   endtask : rd

   task automatic waitIdle();
      for (int k = 0; k < 100 && syncInProgress !== 1'b0; k++) @(negedge sys_clk);
      hang(syncInProgress !== 1'b0);
   endtask : waitIdle

   // Main sequence
   initial begin
      sys_clk = 1'b0;
      rst_b = 1'b0;
      coreClkRun = 1'b1;
      void'($urandom(32'h67b5));
      r = $urandom;
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
      for (i = 0; i < 6; i++) rd(offs[i], RST_WORD, '1);
      `CHK(lat, 10)
      `CHK(syncInProgress, 1'b0)
      wr(OFF_SCRATCH, r);
      wr(6'h3c, r);
      rd(6'h3c, '0, '1);
      rd(OFF_SCRATCH, r, '1);
      `CHK(lat, 2)
      wr(OFF_CORECFG, r + 1);
      rd(OFF_STATUS, 32'h1, '1);
      `CHK(lat, 2)
      rd(OFF_CORECFG, r + 1, '1);
      `CHK(lat > 2, 1'b1)
      wr(OFF_CORECFG, r);
      wr(OFF_CORECFG, ~r);
      `CHK(lat > 2, 1'b1)
      wr(OFF_COUNT, r);
      rd(OFF_COUNT, r, '1);
      `CHK(lat > 10, 1'b1)
      rd(OFF_CORECFG, ~r, '1);
      `CHK(lat, 2)
      wr(OFF_READ_REQUEST_REGISTER, 32'h8000 | OFF_COUNT); // byte offset of target
      @(negedge sys_clk);
      `CHK(syncInProgress, 1'b1)
      waitIdle();
      rd(OFF_COUNT, r, '1);
      `CHK(lat, 2)
      rd(OFF_COUNT, r, '1);
      `CHK(lat, 2)
      wr(OFF_CORECFG, r);
      waitIdle();
      rd(OFF_COUNT, r, '1);
      `CHK(lat, 10)
      wr(OFF_CTRL, 32'h2);
      rd(OFF_CTRL, 32'h2, '1);
      `CHK(lat, 2)
      wr(OFF_SCRATCH, r);
      `CHK(lat > 2, 1'b1)
      waitIdle();
      `CHK(coreEnable, 1'b1)
      wr(OFF_READ_REQUEST_REGISTER, 32'h4000 | OFF_COUNT);
      waitIdle();
      repeat (30) @(negedge sys_clk);
      `CHK(syncInProgress, 1'b0)
      rd(OFF_COUNT, '0, '0);
      `CHK(lat, 2)
      // Capture must track the running counter, not the stale value r
      @(negedge sys_clk);
      `CHK(lastRd - r > 32'd20 && lastRd - r < 32'd200, 1'b1)
      // Core clock stopped: crossings hold until it runs again
      @(posedge sys_clk);
      coreClkRun <= 1'b0;
      wr(OFF_CORECFG, r);
      repeat (20) @(negedge sys_clk);
      `CHK(syncInProgress, 1'b1)
      @(posedge sys_clk);
      coreClkRun <= 1'b1;
      waitIdle();
      wr(OFF_CTRL, 32'h1);
      rd(OFF_CTRL, 32'h1, 32'h1);
      waitIdle();
      rd(OFF_CTRL, '0, '1);
      rd(OFF_SCRATCH, '0, '1);
      `CHK(coreEnable, 1'b0)
      tally_and_finish();
   end
endmodule : peripheral_register_synchronizer_tb
